// ### rtl/pulse_rate_accumulate_counter.sv
// Four-channel pulse counter in two pairs, rate or accumulate mode,
// with port chip-select decoding and an AXI4-Lite register slave.
// Assumes all inputs are synchronous to I_CORE_CLK.
//
// Contract
// - Status shows one gate bit per pair
// - Status shows one rate-mode bit per pair
// - Strobe low plus code selects one port
// - Two cascaded 12-bit counters per channel, readable
// - Count advances on trailing pulse edge
// - Rate mode: gate blocks pulses, counts hold
// - Rate mode: one clear resets pair counters
// - Set opens gate, interval runs, counts advance
// - Interval expiry closes gate, signals done
// - Accumulate: mode low, no clear, all pulses
// - First counter top-bit fall advances second
// - Accumulate counts freely, read periodically
`timescale 1ns/1ps
`default_nettype none

`include "prac_defs.svh"

module pulse_rate_accumulate_counter #(
	parameter int CHANNELS       = 4,
	parameter int INTERVAL_WIDTH = 16,
	parameter int TICK_CYCLES    = `PRAC_TICK_CYCLES
) (
	input  wire logic        I_CORE_CLK,
	input  wire logic        I_RESET_N,
	input  wire logic [3:0]  I_FIELD_PULSE,
	input  wire logic [1:0]  I_PAIR_RATE_SWITCH,
	input  wire logic        I_PORT_SELECT_STROBE_N,
	input  wire logic [2:0]  I_PORT_CODE,
	output logic      [7:0]  O_PORT_CHIP_SELECT_N,
	output prac_pkg::pair_status_s [1:0] O_PAIR_STATUS,
	output logic             O_IRQ,
	input  wire logic [7:0]  I_AXI_AWADDR,
	input  wire logic        I_AXI_AWVALID,
	output logic             O_AXI_AWREADY,
	input  wire logic [31:0] I_AXI_WDATA,
	input  wire logic [3:0]  I_AXI_WSTRB,
	input  wire logic        I_AXI_WVALID,
	output logic             O_AXI_WREADY,
	output logic [1:0]       O_AXI_BRESP,
	output logic             O_AXI_BVALID,
	input  wire logic        I_AXI_BREADY,
	input  wire logic [7:0]  I_AXI_ARADDR,
	input  wire logic        I_AXI_ARVALID,
	output logic             O_AXI_ARREADY,
	output logic [31:0]      O_AXI_RDATA,
	output logic [1:0]       O_AXI_RRESP,
	output logic             O_AXI_RVALID,
	input  wire logic        I_AXI_RREADY
);
	import prac_pkg::*;

	localparam int TICK_W = $clog2(TICK_CYCLES + 1);

	// Write channel holding registers
	logic                      aw_held;
	logic [7:0]                aw_addr;
	logic                      w_held;
	logic [31:0]               w_data;
	logic [3:0]                w_strb;
	logic                      do_write;
	logic                      write_err;
	logic [31:0]               wmask;

	// Read side
	logic                      ar_take;
	logic [31:0]               read_word;
	logic                      read_err;

	// Software state
	logic [INTERVAL_WIDTH-1:0] interval [2];
	logic [`PRAC_IRQ_WIDTH-1:0] irq_status;
	logic [`PRAC_IRQ_WIDTH-1:0] irq_mask;
	logic [`PRAC_IRQ_WIDTH-1:0] irq_event;
	pair_cmd_s [1:0]           pair_cmd;

	// Counting state
	logic [TICK_W-1:0]         tick_count;
	logic                      tick;
	logic [1:0]                pair_sample_gate;
	logic [1:0]                pair_rate_selected;
	logic [1:0]                pair_counter_clear_n;
	logic [1:0]                window_expire;
	logic [INTERVAL_WIDTH-1:0] remaining [2];
	logic [3:0]                pulse_prev;
	logic [3:0]                count_advance;
	logic [3:0]                count_wrap;
	count_t                    count [4];

	// Byte-lane mask of the pending write
	assign wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};

	// ---------------- Port chip-select decoder ----------------
	// Exactly one select low the cycle after the strobe is low, all high otherwise
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESET_N) begin
			O_PORT_CHIP_SELECT_N <= 8'hff;
		end else if (!I_PORT_SELECT_STROBE_N) begin
			O_PORT_CHIP_SELECT_N <= ~(8'h01 << I_PORT_CODE);
		end else begin
			O_PORT_CHIP_SELECT_N <= 8'hff;
		end
	end

	// ---------------- AXI4-Lite write path ----------------
	// Address and data are taken in either order and held until both arrive
	assign O_AXI_AWREADY = ~aw_held & ~O_AXI_BVALID;
	assign O_AXI_WREADY  = ~w_held & ~O_AXI_BVALID;
	assign do_write      = aw_held & w_held & ~O_AXI_BVALID;

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESET_N) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (O_AXI_AWREADY && I_AXI_AWVALID) begin
			aw_held <= 1'b1;
			aw_addr <= I_AXI_AWADDR;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESET_N) begin
			w_held <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else if (O_AXI_WREADY && I_AXI_WVALID) begin
			w_held <= 1'b1;
			w_data <= I_AXI_WDATA;
			w_strb <= I_AXI_WSTRB;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// Writable offsets; anything else answers SLVERR and changes nothing
	always_comb begin
		unique case (aw_addr)
			`PRAC_OFS_CTRL, `PRAC_OFS_INTERVAL_A, `PRAC_OFS_INTERVAL_B,
			`PRAC_OFS_IRQ_STATUS, `PRAC_OFS_IRQ_MASK: write_err = 1'b0;
			default: write_err = 1'b1;
		endcase
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESET_N) begin
			O_AXI_BVALID <= 1'b0;
			O_AXI_BRESP  <= RESP_OKAY;
		end else if (do_write) begin
			O_AXI_BVALID <= 1'b1;
			O_AXI_BRESP  <= write_err ? RESP_SLVERR : RESP_OKAY;
		end else if (I_AXI_BREADY) begin
			O_AXI_BVALID <= 1'b0;
		end
	end

	// Control writes become one-cycle commands; only lane 0 carries them
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESET_N) begin
			pair_cmd <= '0;
		end else begin
			for (int p = 0; p < 2; p++) begin
				pair_cmd[p].window_latch_set <= do_write && aw_addr == `PRAC_OFS_CTRL
					&& w_strb[0] && w_data[`PRAC_CTRL_SET_POS + p];
				pair_cmd[p].counter_clear    <= do_write && aw_addr == `PRAC_OFS_CTRL
					&& w_strb[0] && w_data[`PRAC_CTRL_CLEAR_POS + p];
			end
		end
	end

	// Sampling intervals, in ticks; a write during a window affects the next one
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESET_N) begin
			interval[0] <= `PRAC_INTERVAL_RST;
			interval[1] <= `PRAC_INTERVAL_RST;
		end else if (do_write && aw_addr == `PRAC_OFS_INTERVAL_A) begin
			interval[0] <= (interval[0] & ~wmask[INTERVAL_WIDTH-1:0])
				| (w_data[INTERVAL_WIDTH-1:0] & wmask[INTERVAL_WIDTH-1:0]);
		end else if (do_write && aw_addr == `PRAC_OFS_INTERVAL_B) begin
			interval[1] <= (interval[1] & ~wmask[INTERVAL_WIDTH-1:0])
				| (w_data[INTERVAL_WIDTH-1:0] & wmask[INTERVAL_WIDTH-1:0]);
		end
	end

	// ---------------- Interrupts ----------------
	assign irq_event = {count_wrap, window_expire};

	// A new event in the clearing cycle survives: set wins over write-one-clear
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESET_N) begin
			irq_status <= '0;
		end else if (do_write && aw_addr == `PRAC_OFS_IRQ_STATUS) begin
			irq_status <= (irq_status & ~(w_data[`PRAC_IRQ_WIDTH-1:0]
				& wmask[`PRAC_IRQ_WIDTH-1:0])) | irq_event;
		end else begin
			irq_status <= irq_status | irq_event;
		end
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESET_N) begin
			irq_mask <= `PRAC_IRQ_MASK_RST;
		end else if (do_write && aw_addr == `PRAC_OFS_IRQ_MASK) begin
			irq_mask <= (irq_mask & ~wmask[`PRAC_IRQ_WIDTH-1:0])
				| (w_data[`PRAC_IRQ_WIDTH-1:0] & wmask[`PRAC_IRQ_WIDTH-1:0]);
		end
	end

	assign O_IRQ = |(irq_status & irq_mask);

	// ---------------- AXI4-Lite read path ----------------
	// One read at a time; data leave from a register one cycle after the address
	assign O_AXI_ARREADY = ~O_AXI_RVALID;
	assign ar_take       = I_AXI_ARVALID & O_AXI_ARREADY;

	always_comb begin
		read_word = 32'h0000_0000;
		read_err  = 1'b0;
		unique case (I_AXI_ARADDR)
			`PRAC_OFS_CTRL:       read_word = 32'h0000_0000;
			`PRAC_OFS_STATUS: begin
				read_word[`PRAC_STAT_GATE_POS +: 2] = pair_sample_gate;
				read_word[`PRAC_STAT_RATE_POS +: 2] = pair_rate_selected;
			end
			`PRAC_OFS_INTERVAL_A: read_word[INTERVAL_WIDTH-1:0] = interval[0];
			`PRAC_OFS_INTERVAL_B: read_word[INTERVAL_WIDTH-1:0] = interval[1];
			`PRAC_OFS_IRQ_STATUS: read_word[`PRAC_IRQ_WIDTH-1:0] = irq_status;
			`PRAC_OFS_IRQ_MASK:   read_word[`PRAC_IRQ_WIDTH-1:0] = irq_mask;
			`PRAC_OFS_COUNT_0:    read_word[23:0] = count[0];
			`PRAC_OFS_COUNT_1:    read_word[23:0] = count[1];
			`PRAC_OFS_COUNT_2:    read_word[23:0] = count[2];
			`PRAC_OFS_COUNT_3:    read_word[23:0] = count[3];
			default:              read_err = 1'b1;
		endcase
	end

	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESET_N) begin
			O_AXI_RVALID <= 1'b0;
			O_AXI_RDATA  <= 32'h0000_0000;
			O_AXI_RRESP  <= RESP_OKAY;
		end else if (ar_take) begin
			O_AXI_RVALID <= 1'b1;
			O_AXI_RDATA  <= read_word;
			O_AXI_RRESP  <= read_err ? RESP_SLVERR : RESP_OKAY;
		end else if (I_AXI_RREADY) begin
			O_AXI_RVALID <= 1'b0;
		end
	end

	// ---------------- Interval time base ----------------
	// Free-running divider; a window may start anywhere inside a tick period,
	// so its length is interval ticks minus less than one tick
	always_ff @(posedge I_CORE_CLK) begin
		if (!I_RESET_N) begin
			tick_count <= '0;
		end else if (tick) begin
			tick_count <= '0;
		end else begin
			tick_count <= tick_count + {{(TICK_W-1){1'b0}}, 1'b1};
		end
	end

	assign tick = (tick_count == TICK_W'(TICK_CYCLES - 1));

	// ---------------- Per-pair mode, gate and interval ----------------
	generate
		for (genvar p = 0; p < 2; p++) begin : g_pair
			// Mode straight from the slide switch
			assign pair_rate_selected[p] = I_PAIR_RATE_SWITCH[p];

			// Clear reaches the counters only in rate mode
			assign pair_counter_clear_n[p] = ~(pair_cmd[p].counter_clear
				& pair_rate_selected[p]);

			// Expiry on the tick that consumes the last interval step
			assign window_expire[p] = pair_sample_gate[p] & tick
				& (remaining[p] <= {{(INTERVAL_WIDTH-1){1'b0}}, 1'b1});

			// Window latch: expiry beats a set in the same cycle
			always_ff @(posedge I_CORE_CLK) begin
				if (!I_RESET_N) begin
					pair_sample_gate[p] <= 1'b0;
				end else if (window_expire[p]) begin
					pair_sample_gate[p] <= 1'b0;
				end else if (pair_cmd[p].window_latch_set) begin
					pair_sample_gate[p] <= 1'b1;
				end
			end

			// Interval counter loads on set and runs only while the gate is high
			always_ff @(posedge I_CORE_CLK) begin
				if (!I_RESET_N) begin
					remaining[p] <= '0;
				end else if (pair_cmd[p].window_latch_set && !pair_sample_gate[p]) begin
					remaining[p] <= interval[p];
				end else if (pair_sample_gate[p] && tick && !window_expire[p]) begin
					remaining[p] <= remaining[p] - {{(INTERVAL_WIDTH-1){1'b0}}, 1'b1};
				end
			end

			assign O_PAIR_STATUS[p].gate_status   = pair_sample_gate[p];
			assign O_PAIR_STATUS[p].rate_selected = pair_rate_selected[p];
		end
	endgenerate

	// ---------------- Per-channel pulse path ----------------
	generate
		for (genvar c = 0; c < CHANNELS; c++) begin : g_chan
			// Previous input level for edge detection
			always_ff @(posedge I_CORE_CLK) begin
				if (!I_RESET_N) begin
					pulse_prev[c] <= 1'b0;
				end else begin
					pulse_prev[c] <= I_FIELD_PULSE[c];
				end
			end

			// Inverted pulse rises on the trailing edge; one edge per clock is
			// far above the maximum field rate, so none is dropped
			assign count_advance[c] = pulse_prev[c] & ~I_FIELD_PULSE[c]
				& (~pair_rate_selected[c/2] | pair_sample_gate[c/2]);

			cascade_counter #(
				.WIDTH     (12)
			) u_counter (
				.i_clk     (I_CORE_CLK),
				.i_reset_n (I_RESET_N),
				.i_clear   (~pair_counter_clear_n[c/2]),
				.i_advance (count_advance[c]),
				.o_count   (count[c]),
				.o_wrap    (count_wrap[c])
			);
		end
	endgenerate
endmodule

`default_nettype wire

// ### shared/prac_defs.svh
// Constants of the four-channel pulse rate / accumulate counter.
// Assumes inclusion by bare name; holds definitions only.
`ifndef PRAC_DEFS_SVH
`define PRAC_DEFS_SVH

// Register byte offsets on the AXI4-Lite slave
`define PRAC_OFS_CTRL        8'h00
`define PRAC_OFS_STATUS      8'h04
`define PRAC_OFS_INTERVAL_A  8'h08
`define PRAC_OFS_INTERVAL_B  8'h0c
`define PRAC_OFS_IRQ_STATUS  8'h10
`define PRAC_OFS_IRQ_MASK    8'h14
`define PRAC_OFS_COUNT_0     8'h20
`define PRAC_OFS_COUNT_1     8'h24
`define PRAC_OFS_COUNT_2     8'h28
`define PRAC_OFS_COUNT_3     8'h2c

// Control register fields (write one to act, reads as zero)
`define PRAC_CTRL_SET_POS    0
`define PRAC_CTRL_CLEAR_POS  4

// Status register fields
`define PRAC_STAT_GATE_POS   0
`define PRAC_STAT_RATE_POS   2

// Interrupt fields: bits 1..0 window done per pair, bits 5..2 count wrap per channel
`define PRAC_IRQ_DONE_POS    0
`define PRAC_IRQ_WRAP_POS    2
`define PRAC_IRQ_WIDTH       6

// Reset values
`define PRAC_INTERVAL_RST    16'h0000
`define PRAC_IRQ_MASK_RST    6'h00

// Timing: the interval counter advances once per tick
`define PRAC_CLK_PERIOD_NS   100
`define PRAC_TICK_PERIOD_NS  1000
`define PRAC_TICK_CYCLES     ((`PRAC_TICK_PERIOD_NS + `PRAC_CLK_PERIOD_NS - 1) / `PRAC_CLK_PERIOD_NS)

`endif

// ### shared/prac_pkg.sv
// Types shared by the pulse counter design files.
// Assumes prac_defs.svh supplies the numeric constants.
package prac_pkg;

	// Per-pair view presented on the O_PAIR_STATUS output port
	typedef struct packed {
		logic rate_selected;
		logic gate_status;
	} pair_status_s;

	// Per-pair one-cycle commands decoded from a control write
	typedef struct packed {
		logic window_latch_set;
		logic counter_clear;
	} pair_cmd_s;

	typedef logic [23:0] count_t;

	// AXI response codes
	typedef enum logic [1:0] {
		RESP_OKAY   = 2'b00,
		RESP_SLVERR = 2'b10
	} axi_resp_e;

endpackage

// ### rtl/cascade_counter.sv
// Two cascaded counters of one pulse channel.
// Assumes i_advance is a one-cycle pulse per counted edge.
`timescale 1ns/1ps
`default_nettype none

module cascade_counter #(
	parameter int WIDTH = 12
) (
	input  wire logic               i_clk,
	input  wire logic               i_reset_n,
	input  wire logic               i_clear,
	input  wire logic               i_advance,
	output logic [2*WIDTH-1:0]      o_count,
	output logic                    o_wrap
);
	logic [WIDTH-1:0] low;
	logic [WIDTH-1:0] high;
	logic [WIDTH-1:0] next_low;
	logic             low_msb_fall;

	// First stage next value and the fall of its top bit
	assign next_low     = low + {{(WIDTH-1){1'b0}}, 1'b1};
	assign low_msb_fall = i_advance & low[WIDTH-1] & ~next_low[WIDTH-1];

	// Clear wins over a pulse in the same cycle
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || i_clear) begin
			low  <= '0;
			high <= '0;
		end else if (i_advance) begin
			low <= next_low;
			if (low_msb_fall) begin
				high <= high + {{(WIDTH-1){1'b0}}, 1'b1};
			end
		end
	end

	// Wrap pulse when the whole cascade rolls to zero
	always_ff @(posedge i_clk) begin
		if (!i_reset_n || i_clear) begin
			o_wrap <= 1'b0;
		end else begin
			o_wrap <= low_msb_fall & (&high);
		end
	end

	assign o_count = {high, low};
endmodule

`default_nettype wire

// ### test/prac_asserts.sv
// Checker for the pulse counter top: decoder, status and bus handshakes.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module prac_asserts (
	input wire logic                         I_CORE_CLK,
	input wire logic                         I_RESET_N,
	input wire logic [1:0]                   I_PAIR_RATE_SWITCH,
	input wire logic                         I_PORT_SELECT_STROBE_N,
	input wire logic [2:0]                   I_PORT_CODE,
	input wire logic [7:0]                   O_PORT_CHIP_SELECT_N,
	input wire prac_pkg::pair_status_s [1:0] O_PAIR_STATUS,
	input wire logic                         O_IRQ,
	input wire logic                         O_AXI_AWREADY,
	input wire logic                         O_AXI_WREADY,
	input wire logic [1:0]                   O_AXI_BRESP,
	input wire logic                         O_AXI_BVALID,
	input wire logic                         I_AXI_BREADY,
	input wire logic                         I_AXI_ARVALID,
	input wire logic                         O_AXI_ARREADY,
	input wire logic [31:0]                  O_AXI_RDATA,
	input wire logic [1:0]                   O_AXI_RRESP,
	input wire logic                         O_AXI_RVALID,
	input wire logic                         I_AXI_RREADY
);
	import prac_pkg::*;

	// One clock domain, so clocking and reset are given once
	default clocking cb @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RESET_N);

	// Decoder is registered: the select follows the code one cycle later
	AST_CS_SEL: assert property (!I_PORT_SELECT_STROBE_N |=>
		O_PORT_CHIP_SELECT_N == ~(8'h01 << $past(I_PORT_CODE))) else $error("wrong chip select");
	AST_CS_IDLE: assert property (I_PORT_SELECT_STROBE_N |=> &O_PORT_CHIP_SELECT_N)
		else $error("chip select active without strobe");
	AST_CS_ONE: assert property ($onehot0(~O_PORT_CHIP_SELECT_N))
		else $error("more than one chip select");
	AST_RATE: assert property ({O_PAIR_STATUS[1].rate_selected,
		O_PAIR_STATUS[0].rate_selected} == I_PAIR_RATE_SWITCH) else $error("mode bit wrong");
	// A gate only opens the cycle after a write response rose
	AST_GATE_CAUSE: assert property ($rose(O_PAIR_STATUS[0].gate_status) ||
		$rose(O_PAIR_STATUS[1].gate_status) |-> $past(O_AXI_BVALID))
		else $error("gate opened without a write");
	AST_RST_VAL: assert property ($rose(I_RESET_N) |-> !O_IRQ &&
		!O_PAIR_STATUS[0].gate_status && !O_PAIR_STATUS[1].gate_status)
		else $error("status not cleared by reset");
	// Responses stand until taken; a stall must not disturb them
	AST_B_HOLD: assert property (O_AXI_BVALID && !I_AXI_BREADY |=>
		O_AXI_BVALID && $stable(O_AXI_BRESP)) else $error("write response dropped");
	AST_R_HOLD: assert property (O_AXI_RVALID && !I_AXI_RREADY |=>
		O_AXI_RVALID && $stable(O_AXI_RDATA) && $stable(O_AXI_RRESP))
		else $error("read data dropped");
	AST_AR_REFUSE: assert property (O_AXI_ARREADY == !O_AXI_RVALID)
		else $error("read address ready wrong");
	// Read answer has a fixed latency of one cycle
	AST_R_LATENCY: assert property (I_AXI_ARVALID && O_AXI_ARREADY |=>
		O_AXI_RVALID) else $error("read answer not one cycle after address");
	AST_W_REFUSE: assert property (O_AXI_BVALID |-> !O_AXI_AWREADY && !O_AXI_WREADY)
		else $error("write taken while response pending");

	// Main scenarios reached
	COV_GATE: cover property ($rose(O_PAIR_STATUS[0].gate_status));
	COV_IRQ: cover property ($rose(O_IRQ));
	COV_CS: cover property (!(&O_PORT_CHIP_SELECT_N));
	COV_ERR: cover property (O_AXI_RVALID && O_AXI_RRESP == RESP_SLVERR);
endmodule

bind pulse_rate_accumulate_counter prac_asserts u_chk (
	.I_CORE_CLK, .I_RESET_N, .I_PAIR_RATE_SWITCH, .I_PORT_SELECT_STROBE_N,
	.I_PORT_CODE, .O_PORT_CHIP_SELECT_N, .O_PAIR_STATUS, .O_IRQ, .O_AXI_AWREADY,
	.O_AXI_WREADY, .O_AXI_BRESP, .O_AXI_BVALID, .I_AXI_BREADY, .I_AXI_ARVALID,
	.O_AXI_ARREADY,
	.O_AXI_RDATA, .O_AXI_RRESP, .O_AXI_RVALID, .I_AXI_RREADY
);

`default_nettype wire

// ### test/field_source.sv
// Model of the conditioned field pulse lines feeding the counter.
// Assumes the caller runs its tasks one at a time from the bench.
`timescale 1ns/1ps
`default_nettype none

module field_source (
	input  wire logic  i_clk,
	output logic [3:0] o_pulse
);
	// Lines idle low until a burst is asked for
	initial o_pulse = 4'h0;

	// One pulse per two cycles, far above the rated field rate
	task burst(input int ch, input int n);
		repeat (n) begin
			@(posedge i_clk);
			o_pulse[ch] <= 1'b1;
			@(posedge i_clk);
			o_pulse[ch] <= 1'b0; // Trailing edge is the counted one
		end
	endtask

	// Holds a line at a level so edge sensitivity can be probed
	task level(input int ch, input logic v);
		@(posedge i_clk);
		o_pulse[ch] <= v;
	endtask
endmodule

`default_nettype wire

// ### test/tb.sv
// Self-checking bench: AXI4-Lite master tasks and directed tests.
// Assumes the design package and the field pulse model compile first.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
	$display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb;
	import prac_pkg::*;

	logic        clk, rst_n, strb_n, awv, wv, bry, arv, rry;
	logic        awr, wrd, bvld, arr, rvld, irq;
	logic [1:0]  sw, bresp, rresp, r;
	logic [2:0]  code;
	logic [3:0]  pulse, ws;
	pair_status_s [1:0] pst;
	logic [7:0]  awa, ara, cs_n;
	logic [31:0] wd, rdata, d;
	int          num_errors, checked;

	field_source src (.i_clk(clk), .o_pulse(pulse));

	// Short tick keeps sample windows brief
	pulse_rate_accumulate_counter #(.TICK_CYCLES(2)) u_dut (
		.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_FIELD_PULSE(pulse),
		.I_PAIR_RATE_SWITCH(sw), .I_PORT_SELECT_STROBE_N(strb_n), .I_PORT_CODE(code),
		.O_PORT_CHIP_SELECT_N(cs_n), .O_PAIR_STATUS(pst), .O_IRQ(irq),
		.I_AXI_AWADDR(awa), .I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr),
		.I_AXI_WDATA(wd), .I_AXI_WSTRB(ws), .I_AXI_WVALID(wv), .O_AXI_WREADY(wrd),
		.O_AXI_BRESP(bresp), .O_AXI_BVALID(bvld), .I_AXI_BREADY(bry),
		.I_AXI_ARADDR(ara), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr),
		.O_AXI_RDATA(rdata), .O_AXI_RRESP(rresp), .O_AXI_RVALID(rvld), .I_AXI_RREADY(rry)
	);

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Ready is raised only after valid shows, so each answer stalls one cycle
	task wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		awa <= a; wd <= v; awv <= 1'b1; wv <= 1'b1;
		forever begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrd) wv <= 1'b0;
			if (bvld && bry) begin
				r = bresp; bry <= 1'b0; break;
			end
			if (bvld) bry <= 1'b1;
		end
	endtask

	task rd(input logic [7:0] a);
		@(posedge clk);
		ara <= a; arv <= 1'b1;
		forever begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
			if (rvld && rry) begin
				d = rdata; r = rresp; rry <= 1'b0; break;
			end
			if (rvld) rry <= 1'b1;
		end
	endtask

	task rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		`CHK(d, e)
	endtask

	// Polls the status word for a gate level, bounded
	task gate(input int i, input logic v);
		rd(8'h04);
		for (int k = 0; k < 300 && d[i] !== v; k++) rd(8'h04);
		`CHK(d[i], v)
		`CHK(pst[i].gate_status, v)
	endtask

	task cs(input logic s, input logic [2:0] c, input logic [7:0] e);
		@(posedge clk);
		strb_n <= s; code <= c;
		repeat (2) @(posedge clk);
		`CHK(cs_n, e)
	endtask

	task summarize;
		$display("counts errors=%0d checks=%0d", num_errors, checked);
		if (num_errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Watchdog: tests need about ten thousand cycles
	initial begin
		#4000000;
		num_errors++;
		summarize();
	end

	initial begin
		rst_n = 1'b0; strb_n = 1'b1; code = 3'h0; sw = 2'b01;
		awv = 1'b0; wv = 1'b0; bry = 1'b0; arv = 1'b0; rry = 1'b0;
		awa = 8'h00; ara = 8'h00; wd = 32'h0; num_errors = 0; checked = 0;
		ws = 4'hf;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		// Reset values, access kinds, refused places
		rc(8'h04, 32'h4);
		rc(8'h08, 32'h0);
		rc(8'h14, 32'h0);
		rc(8'h20, 32'h0);
		wr(8'h0c, 32'hffffbeef);
		`CHK(r, RESP_OKAY)
		rc(8'h0c, 32'hbeef);
		// Only byte lane 1 is written; the other lanes keep their value
		ws <= 4'h2;
		wr(8'h0c, 32'h00001200);
		ws <= 4'hf;
		rc(8'h0c, 32'h12ef);
		wr(8'h04, 32'h1);
		`CHK(r, RESP_SLVERR)
		rc(8'h40, 32'h0);
		`CHK(r, RESP_SLVERR)
		$display("test registers done");
		for (int k = 0; k < 8; k++) cs(1'b0, k[2:0], ~(8'h01 << k));
		cs(1'b1, 3'h5, 8'hff);
		$display("test decoder done");
		// Rate window on pair A: interval, clear, then set
		wr(8'h08, 32'd40);
		wr(8'h00, 32'h10);
		wr(8'h00, 32'h01);
		gate(0, 1'b1);
		src.burst(0, 3);
		src.burst(1, 2);
		gate(0, 1'b0);
		rc(8'h20, 32'd3);
		rc(8'h24, 32'd2);
		src.burst(0, 2);
		rc(8'h20, 32'd3);
		rc(8'h10, 32'h1);
		`CHK(irq, 1'b0)
		wr(8'h14, 32'h1);
		@(posedge clk);
		`CHK(irq, 1'b1)
		wr(8'h10, 32'h1);
		@(posedge clk);
		`CHK(irq, 1'b0)
		wr(8'h00, 32'h10);
		rc(8'h20, 32'h0);
		rc(8'h24, 32'h0);
		$display("test rate done");
		// Accumulate on pair B: trailing edge, no clear, cascade carry
		src.level(2, 1'b1);
		repeat (3) @(posedge clk);
		rc(8'h28, 32'h0);
		src.level(2, 1'b0);
		repeat (3) @(posedge clk);
		rc(8'h28, 32'h1);
		src.burst(2, 4);
		wr(8'h00, 32'h20);
		rc(8'h28, 32'd5);
		src.burst(3, 4096);
		repeat (3) @(posedge clk);
		rc(8'h2c, 32'h1000);
		rc(8'h04, 32'h4);
		$display("test accumulate done");
		// Rate window on pair B: switch to rate, short interval, clear, set
		sw <= 2'b11;
		wr(8'h0c, 32'd8);
		wr(8'h00, 32'h20);
		rc(8'h28, 32'h0);
		rc(8'h2c, 32'h0);
		wr(8'h00, 32'h02);
		gate(1, 1'b1);
		gate(1, 1'b0);
		rc(8'h10, 32'h2);
		rc(8'h04, 32'hc);
		$display("test pair b done");
		summarize();
	end
endmodule

`default_nettype wire
